// ==== design/cpri_phy_test_harness.sv ====
// cpri phy test harness: alignment wait, hyperframe traffic, latency, decode
`timescale 1ns/10ps
module cpri_phy_test_harness
  import cpri_harness_pkg::*;
#(
  parameter int HF_COUNT = HF_TARGET,
  parameter int LW = LAT_W
)(
  // csr_clock_in domain; sampling clock is the same single clock here
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire rate_t i_rate,
  input wire logic i_start,
  input wire logic i_rx_aligned,
  input wire logic i_rx_hf_valid,
  input wire logic i_rx_hf_start,
  input wire logic [7:0] i_rx_data,
  input wire logic i_csr_read,
  input wire logic i_csr_write,
  input wire logic [ADDR_W-1:0] i_csr_addr,
  input wire logic [DATA_W-1:0] i_csr_wdata,
  input wire logic [DATA_W-1:0] i_cpri_rdata,
  input wire logic [DATA_W-1:0] i_fec_rdata,
  input wire logic [DATA_W-1:0] i_xcvr_rdata,
  output logic o_tx_valid,
  output logic o_tx_hf_start,
  output logic [7:0] o_tx_data,
  output logic o_use_8b10b,
  output logic o_fec_enable,
  output logic [NUM_CH-1:0] o_cpri_sel,
  output logic [NUM_CH-1:0] o_xcvr_sel,
  output logic o_fec_sel,
  output logic o_sub_read,
  output logic o_sub_write,
  output logic [ADDR_W-1:0] o_sub_addr,
  output logic [DATA_W-1:0] o_sub_wdata,
  output logic [DATA_W-1:0] o_csr_rdata,
  output logic [LW-1:0] o_latency,
  output logic o_done,
  output logic o_pass
);
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_ALIGN, S_SEND, S_REPORT
  } state_t;

  state_t state, next_state;
  logic [7:0] tx_cnt, next_tx_cnt;
  logic [7:0] exp_cnt, next_exp_cnt;
  logic [3:0] hf_rx, next_hf_rx;
  logic [LW-1:0] lat_cnt, next_lat_cnt;
  logic lat_run, next_lat_run;
  logic lat_done, next_lat_done;
  logic [LW-1:0] latency, next_latency;
  logic err, next_err;
  logic done, next_done;
  logic pass, next_pass;
  logic [DATA_W-1:0] rdata, next_rdata;
  target_t tgt;
  logic [1:0] chan;
  logic [ADDR_W-1:0] local_addr;

  cpri_addr_decoder u_dec (
    .i_addr(i_csr_addr),
    .i_fec_enable(o_fec_enable),
    .o_target(tgt),
    .o_channel(chan),
    .o_local_addr(local_addr)
  );

  assign o_use_8b10b = (i_rate == RATE_2G4_4G9_9G8);
  assign o_fec_enable = (i_rate == RATE_24G3_FEC);

  // strobes reach a region only when decoded; unmapped goes nowhere
  always_comb begin
    o_cpri_sel = '0;
    o_xcvr_sel = '0;
    o_fec_sel = 1'b0;
    if (tgt == TGT_CPRI) o_cpri_sel[chan] = 1'b1;
    if (tgt == TGT_XCVR) o_xcvr_sel[chan] = 1'b1;
    if (tgt == TGT_FEC) o_fec_sel = 1'b1;
  end
  assign o_sub_read = i_csr_read && tgt != TGT_NONE;
  assign o_sub_write = i_csr_write && tgt != TGT_NONE;
  assign o_sub_addr = local_addr;
  assign o_sub_wdata = i_csr_wdata;

  // read data registered: one cycle after the read strobe
  always_comb begin
    next_rdata = rdata;
    if (i_csr_read) begin
      unique case (tgt)
        TGT_CPRI: next_rdata = i_cpri_rdata;
        TGT_FEC: next_rdata = i_fec_rdata;
        TGT_XCVR: next_rdata = i_xcvr_rdata;
        TGT_NONE: next_rdata = '0;
      endcase
    end
  end
  assign o_csr_rdata = rdata;

  always_comb begin
    next_state = state;
    next_tx_cnt = tx_cnt;
    next_exp_cnt = exp_cnt;
    next_hf_rx = hf_rx;
    next_lat_cnt = lat_cnt;
    next_lat_run = lat_run;
    next_lat_done = lat_done;
    next_latency = latency;
    next_err = err;
    next_done = done;
    next_pass = pass;
    unique case (state)
      S_IDLE: begin
        if (i_start) begin
          next_state = S_WAIT_ALIGN;
          next_done = 1'b0;
          next_pass = 1'b0;
          next_err = 1'b0;
          next_hf_rx = '0;
          next_lat_done = 1'b0;
          next_lat_cnt = '0;
          next_tx_cnt = PATTERN_SEED;
          next_exp_cnt = PATTERN_SEED;
        end
      end
      S_WAIT_ALIGN: begin
        if (i_rx_aligned) begin
          next_state = S_SEND;
          next_lat_run = 1'b1;
        end
      end
      S_SEND: begin
        next_tx_cnt = tx_cnt + 8'd1;
        if (lat_run) begin
          next_lat_cnt = lat_cnt + LW'(1);
        end
        if (i_rx_hf_valid) begin
          if (i_rx_hf_start && !lat_done) begin
            next_lat_run = 1'b0;
            next_lat_done = 1'b1;
            next_latency = lat_cnt;
          end
          if (i_rx_data != exp_cnt) next_err = 1'b1;
          next_exp_cnt = i_rx_data + 8'd1;
          if (i_rx_hf_start) next_hf_rx = hf_rx + 4'd1;
        end
        if (!i_rx_aligned) next_err = 1'b1;
        if (hf_rx == 4'(HF_COUNT) && lat_done) begin
          next_state = S_REPORT;
        end
      end
      S_REPORT: begin
        next_done = 1'b1;
        next_pass = !err;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= S_IDLE;
      tx_cnt <= '0;
      exp_cnt <= '0;
      hf_rx <= '0;
      lat_cnt <= '0;
      lat_run <= 1'b0;
      lat_done <= 1'b0;
      latency <= '0;
      err <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      rdata <= '0;
    end else begin
      state <= next_state;
      tx_cnt <= next_tx_cnt;
      exp_cnt <= next_exp_cnt;
      hf_rx <= next_hf_rx;
      lat_cnt <= next_lat_cnt;
      lat_run <= next_lat_run;
      lat_done <= next_lat_done;
      latency <= next_latency;
      err <= next_err;
      done <= next_done;
      pass <= next_pass;
      rdata <= next_rdata;
    end
  end

  assign o_tx_valid = (state == S_SEND);
  assign o_tx_hf_start = (state == S_SEND) && (tx_cnt == PATTERN_SEED);
  assign o_tx_data = tx_cnt;
  assign o_latency = latency;
  assign o_done = done;
  assign o_pass = pass;

  no_tx_unaligned_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(o_tx_valid) |-> $past(i_rx_aligned))
    else $error("traffic started before alignment");
  report_after_hf_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(o_done) |-> hf_rx == 4'(HF_COUNT) && lat_done)
    else $error("report before five hyperframes");
  latency_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    lat_done && $past(lat_done) |-> $stable(latency))
    else $error("latency changed after capture");
  pass_err_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    state == S_REPORT |=> o_done && o_pass == !$past(err))
    else $error("pass flag does not follow data check");
  unmapped_zero_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_csr_read && tgt == TGT_NONE |=> o_csr_rdata == '0)
    else $error("unmapped read not zero");
  no_side_effect_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    tgt == TGT_NONE |-> !o_sub_write && !o_sub_read &&
      o_cpri_sel == '0 && o_xcvr_sel == '0 && !o_fec_sel)
    else $error("unmapped access reached a region");
  fec_only_ch0_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_fec_sel |-> o_fec_enable && i_csr_addr[ADDR_W-1:ADDR_W-3] == 3'h0)
    else $error("fec region selected wrongly");
  xcvr_map_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_csr_addr[ADDR_W-3] |-> o_xcvr_sel[i_csr_addr[ADDR_W-1:ADDR_W-2]])
    else $error("transceiver region not selected");
  iface_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_use_8b10b |-> !o_fec_enable)
    else $error("interface mode conflicts with fec");
  cpri_map_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_csr_addr < FEC_CH0_BASE |-> o_cpri_sel[0])
    else $error("channel 0 cpri region not selected");

  pass_seen_c: cover property (@(posedge i_sys_clk) $rose(o_pass));
  fail_seen_c: cover property (@(posedge i_sys_clk) $rose(o_done) && !o_pass);
  fec_access_c: cover property (@(posedge i_sys_clk) i_csr_write && o_fec_sel);
  unmapped_c: cover property (@(posedge i_sys_clk)
    i_csr_read && tgt == TGT_NONE);
endmodule : cpri_phy_test_harness

// ==== common/cpri_harness_pkg.sv ====
// shared constants for the cpri phy test harness
package cpri_harness_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 4;
  localparam logic [ADDR_W-1:0] CPRI_CH0_BASE = 23'h00_0000;
  localparam logic [ADDR_W-1:0] FEC_CH0_BASE = 23'h01_0000;
  localparam logic [ADDR_W-1:0] XCVR_CH0_BASE = 23'h10_0000;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 23'h20_0000;
  localparam logic [ADDR_W-1:0] XCVR_REL = 23'h10_0000;
  localparam logic [ADDR_W-1:0] FEC_SIZE = 23'h01_0000;
  localparam logic [ADDR_W-1:0] REGION_SIZE = 23'h10_0000;
  localparam logic [ADDR_W-1:0] MAP_END = 23'h7f_ffff;
  localparam int HF_TARGET = 5;
  localparam int LAT_W = 16;
  localparam logic [7:0] PATTERN_SEED = 8'h5a;
  localparam int CSR_CLK_MHZ = 100;
  typedef enum logic [1:0] {
    RATE_2G4_4G9_9G8,
    RATE_10G1,
    RATE_24G3,
    RATE_24G3_FEC
  } rate_t;
  typedef enum logic [1:0] {
    TGT_CPRI,
    TGT_FEC,
    TGT_XCVR,
    TGT_NONE
  } target_t;
endpackage : cpri_harness_pkg

// ==== design/cpri_addr_decoder.sv ====
// reconfiguration address decoder for cpri, fec and transceiver regions
`timescale 1ns/10ps
module cpri_addr_decoder
  import cpri_harness_pkg::*;
(
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_fec_enable,
  output target_t o_target,
  output logic [1:0] o_channel,
  output logic [ADDR_W-1:0] o_local_addr
);
  logic [ADDR_W-1:0] rel;
  always_comb begin
    o_channel = i_addr[ADDR_W-1:ADDR_W-2];
    rel = i_addr - CPRI_CH0_BASE - ADDR_W'(o_channel) * CH_STRIDE;
    o_target = TGT_NONE;
    o_local_addr = '0;
    if (rel >= XCVR_REL) begin
      o_target = TGT_XCVR;
      o_local_addr = rel - XCVR_REL;
    end else if (o_channel == 2'd0 && rel >= FEC_CH0_BASE &&
                 rel < FEC_CH0_BASE + FEC_SIZE) begin
      // fec region exists only on channel 0 at the fec rate
      if (i_fec_enable) begin
        o_target = TGT_FEC;
        o_local_addr = rel - FEC_CH0_BASE;
      end
    end else if (o_channel == 2'd0 && rel < FEC_CH0_BASE) begin
      o_target = TGT_CPRI;
      o_local_addr = rel;
    end else if (o_channel != 2'd0) begin
      o_target = TGT_CPRI;
      o_local_addr = rel;
    end
  end
endmodule : cpri_addr_decoder

// ==== test/cpri_loop_model.sv ====
// loopback model of the cpri core: aligned flag and delayed rx words
`timescale 1ns/10ps
module cpri_loop_model #(
  parameter int DELAY = 6
)(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tx_valid,
  input wire logic i_tx_hf_start,
  input wire logic [7:0] i_tx_data,
  input wire logic i_align_en,
  input wire logic i_corrupt,
  output logic o_rx_aligned,
  output logic o_rx_hf_valid,
  output logic o_rx_hf_start,
  output logic [7:0] o_rx_data
);
  logic [9:0] pipe [DELAY];
  logic [7:0] last;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < DELAY; i++) pipe[i] <= '0;
      last <= '0;
    end else begin
      pipe[0] <= {i_tx_valid, i_tx_hf_start, i_tx_data ^ {8{i_corrupt}}};
      for (int i = 1; i < DELAY; i++) pipe[i] <= pipe[i-1];
      if (o_rx_hf_valid) last <= o_rx_data;
    end
  end
  assign o_rx_aligned = i_align_en;
  assign o_rx_hf_valid = pipe[DELAY-1][9] & i_align_en;
  assign o_rx_hf_start = pipe[DELAY-1][8] & o_rx_hf_valid;
  // idle line shows the inverse so a stale word never looks valid
  assign o_rx_data = o_rx_hf_valid ? pipe[DELAY-1][7:0] : ~last;
endmodule : cpri_loop_model

// ==== test/test_cpri_phy_test_harness.sv ====
// testbench for the cpri phy test harness
`timescale 1ns/10ps
module test_cpri_phy_test_harness;
  import cpri_harness_pkg::*;
  localparam int DLY = 6;
  localparam logic [31:0] RD_C = 32'h1111_1111;
  localparam logic [31:0] RD_F = 32'h2222_2222;
  localparam logic [31:0] RD_X = 32'h3333_3333;
  typedef struct {
    logic [22:0] addr; rate_t rate; target_t tgt; int ch; logic [22:0] loc;
  } row_t;
  row_t rows [14] = '{
    '{23'h00_0004, RATE_2G4_4G9_9G8, TGT_CPRI, 0, 23'h00_0004},
    '{23'h00_ffff, RATE_24G3_FEC, TGT_CPRI, 0, 23'h00_ffff},
    '{23'h01_ffff, RATE_24G3_FEC, TGT_FEC, 0, 23'h00_ffff},
    '{23'h0f_ffff, RATE_24G3_FEC, TGT_NONE, 0, 23'h00_0000},
    '{23'h01_0008, RATE_24G3_FEC, TGT_FEC, 0, 23'h00_0008},
    '{23'h01_0008, RATE_24G3, TGT_NONE, 0, 23'h00_0000},
    '{23'h02_0000, RATE_24G3_FEC, TGT_NONE, 0, 23'h00_0000},
    '{23'h10_0010, RATE_10G1, TGT_XCVR, 0, 23'h00_0010},
    '{23'h20_0000, RATE_10G1, TGT_CPRI, 1, 23'h00_0000},
    '{23'h3f_ffff, RATE_2G4_4G9_9G8, TGT_XCVR, 1, 23'h0f_ffff},
    '{23'h40_0001, RATE_24G3, TGT_CPRI, 2, 23'h00_0001},
    '{23'h50_0002, RATE_24G3_FEC, TGT_XCVR, 2, 23'h00_0002},
    '{23'h60_0003, RATE_10G1, TGT_CPRI, 3, 23'h00_0003},
    '{23'h7f_ffff, RATE_24G3, TGT_XCVR, 3, 23'h0f_ffff}};
  logic i_sys_clk = 0, i_nrst = 0, i_start = 0, align_en = 0, corrupt = 0;
  logic i_csr_read = 0, i_csr_write = 0;
  rate_t i_rate = RATE_10G1;
  logic [ADDR_W-1:0] i_csr_addr = '0;
  logic [DATA_W-1:0] i_csr_wdata = '0;
  logic rx_al, rx_v, rx_s, o_tx_valid, o_tx_hf_start, o_use_8b10b;
  logic o_fec_enable, o_fec_sel, o_sub_read, o_sub_write, o_done, o_pass;
  logic [7:0] rx_d, o_tx_data;
  logic [NUM_CH-1:0] o_cpri_sel, o_xcvr_sel;
  logic [ADDR_W-1:0] o_sub_addr;
  logic [DATA_W-1:0] o_sub_wdata, o_csr_rdata, exp_rd;
  logic [LAT_W-1:0] o_latency;
  logic [3:0] exp_c, exp_x;
  int bad_count = 0, checks = 0, cyc = 0, n;
  always #10 i_sys_clk = ~i_sys_clk;
  cpri_phy_test_harness u_dut (.i_sys_clk, .i_nrst, .i_rate, .i_start,
    .i_rx_aligned(rx_al), .i_rx_hf_valid(rx_v), .i_rx_hf_start(rx_s),
    .i_rx_data(rx_d), .i_csr_read, .i_csr_write, .i_csr_addr, .i_csr_wdata,
    .i_cpri_rdata(RD_C), .i_fec_rdata(RD_F), .i_xcvr_rdata(RD_X),
    .o_tx_valid, .o_tx_hf_start, .o_tx_data, .o_use_8b10b, .o_fec_enable,
    .o_cpri_sel, .o_xcvr_sel, .o_fec_sel, .o_sub_read, .o_sub_write,
    .o_sub_addr, .o_sub_wdata, .o_csr_rdata, .o_latency, .o_done, .o_pass);
  cpri_loop_model #(.DELAY(DLY)) u_loop (.i_clk(i_sys_clk), .i_nrst,
    .i_tx_valid(o_tx_valid), .i_tx_hf_start(o_tx_hf_start),
    .i_tx_data(o_tx_data), .i_align_en(align_en), .i_corrupt(corrupt),
    .o_rx_aligned(rx_al), .o_rx_hf_valid(rx_v), .o_rx_hf_start(rx_s),
    .o_rx_data(rx_d));
  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic run(int mode);
    align_en = 0;
    @(negedge i_sys_clk) i_start = 1;
    @(negedge i_sys_clk) i_start = 0;
    repeat (20) @(negedge i_sys_clk) check("tx_early", o_tx_valid, 0);
    align_en = 1;
    n = 0;
    while (o_tx_valid !== 1'b1 && n < 4) @(negedge i_sys_clk) n++;
    check("tx_first", {o_tx_valid, o_tx_hf_start, o_tx_data}, 10'h35a);
    // mode 1 corrupts one word, mode 2 drops alignment for one cycle
    if (mode != 0) begin
      repeat (300) @(negedge i_sys_clk);
      corrupt = (mode == 1);
      align_en = (mode != 2);
      @(negedge i_sys_clk) corrupt = 0;
      align_en = 1;
    end
    n = 0;
    while (o_done !== 1'b1 && n < 3000) @(negedge i_sys_clk) n++;
    check("done", o_done, 1);
    check("pass", o_pass, mode == 0);
    check("latency", o_latency, DLY);
    @(negedge i_sys_clk) check("tx_idle", o_tx_valid, 0);
    $display("traffic test mode=%0d done", mode);
  endtask : run
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_nrst = 1;
    foreach (rows[i]) begin
      @(negedge i_sys_clk);
      i_rate = rows[i].rate;
      i_csr_addr = rows[i].addr;
      i_csr_wdata = {9'h0, rows[i].addr};
      i_csr_write = 1;
      #1 check("sub_write", o_sub_write, rows[i].tgt != TGT_NONE);
      check("sub_wdata", o_sub_wdata, i_csr_wdata);
      check("8b10b", o_use_8b10b, i_rate == RATE_2G4_4G9_9G8);
      check("fec_en", o_fec_enable, i_rate == RATE_24G3_FEC);
      @(negedge i_sys_clk) {i_csr_write, i_csr_read} = 2'h1;
      exp_c = rows[i].tgt == TGT_CPRI ? 4'h1 << rows[i].ch : 4'h0;
      exp_x = rows[i].tgt == TGT_XCVR ? 4'h1 << rows[i].ch : 4'h0;
      #1 check("cpri_sel", o_cpri_sel, exp_c);
      check("xcvr_sel", o_xcvr_sel, exp_x);
      check("fec_sel", o_fec_sel, rows[i].tgt == TGT_FEC);
      check("sub_read", o_sub_read, rows[i].tgt != TGT_NONE);
      if (rows[i].tgt != TGT_NONE) check("loc", o_sub_addr, rows[i].loc);
      exp_rd = rows[i].tgt == TGT_CPRI ? RD_C : rows[i].tgt == TGT_FEC ? RD_F
        : rows[i].tgt == TGT_XCVR ? RD_X : 32'h0000_0000;
      @(negedge i_sys_clk) i_csr_read = 0;
      check("rdata", o_csr_rdata, exp_rd);
    end
    $display("decode table done");
    run(1);
    run(2);
    run(0);
    // reset with results held must clear them
    @(negedge i_sys_clk) i_nrst = 0;
    #1 check("rst_done", o_done, 0);
    check("rst_pass", o_pass, 0);
    check("rst_lat", o_latency, 0);
    check("rst_rdata", o_csr_rdata, 0);
    @(negedge i_sys_clk) i_nrst = 1;
    repeat (2) @(negedge i_sys_clk) check("rst_idle", o_tx_valid, 0);
    // reset in mid traffic must stop sending, then a new run must pass
    align_en = 1;
    @(negedge i_sys_clk) i_start = 1;
    @(negedge i_sys_clk) i_start = 0;
    repeat (10) @(negedge i_sys_clk);
    check("tx_busy", o_tx_valid, 1);
    i_nrst = 0;
    #1 check("rst_tx", o_tx_valid, 0);
    check("rst_lat2", o_latency, 0);
    @(negedge i_sys_clk) i_nrst = 1;
    run(0);
    $display("reset test done");
    final_report();
  end
endmodule : test_cpri_phy_test_harness
